// >>> flash_host_ctrl.sv
`timescale 1ns/1ps
`include "flash_host_defines.svh"
module flash_host_ctrl
   import flash_host_pkg::*;
#(
   parameter int AW          = 22,
   parameter int DW          = 16,
   parameter int ACC_CYC     = `ACC_CYC,
   parameter int CE_CYC      = `CE_CYC,
   parameter int WP_CYC      = `WP_CYC,
   parameter int RP_CYC      = `RP_CYC,
   parameter int READY_CYC   = `READY_CYC,
   parameter int RH_CYC      = `RH_CYC
) (
   input  wire logic          CLK,
   input  wire logic          RESET_N,
   input  wire logic          REQ_VALID,
   output logic               REQ_READY,
   input  wire host_op_t      REQ_OP,
   input  wire logic [AW-1:0] REQ_ADDR,
   input  wire logic [DW-1:0] REQ_WDATA,
   input  wire logic          REQ_BYTE_MODE,
   input  wire logic          REQ_ACCEL,
   output logic               RSP_VALID,
   output logic [DW-1:0]      RSP_RDATA,
   output logic [1:0]         RSP_BANK,
   output logic               ACCEL_ACTIVE,
   output logic               DEV_BUSY,
   output logic [AW-1:0]      FL_ADDR,
   output logic               FL_CE_N,
   output logic               FL_OE_N,
   output logic               FL_WE_N,
   output logic               FL_RESET_N,
   output logic               WORD_BYTE_SELECT,
   output logic               PROTECT_ACCEL_PIN,
   output logic               ACCEL_HIGH_VOLTAGE,
   input  wire logic          READY_BUSY_N,
   input  wire logic [DW-1:0] DATA_LINES_I,
   output logic [DW-1:0]      DATA_LINES_O,
   output logic               DATA_LINES_OE
);
   localparam int CW = 16;
   localparam int SEL_CYC = (CE_CYC > ACC_CYC) ? CE_CYC : ACC_CYC;
   host_state_t state_reg;
   host_state_t state_next;
   logic [CW-1:0] cnt_reg;
   logic          rdy_sync;
   logic          cnt_zero;

   sync3 u_rdy (
      .clk     (CLK),
      .reset_n (RESET_N),
      .d       (READY_BUSY_N),
      .q       (rdy_sync)
   );

   assign cnt_zero  = (cnt_reg == '0);
   assign REQ_READY = (state_reg == S_IDLE);
   assign DEV_BUSY  = ~rdy_sync;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE: begin
            if (REQ_VALID) begin
               unique case (REQ_OP)
                  OP_READ:  state_next = S_RD;
                  OP_WRITE: state_next = S_WR;
                  OP_RESET: state_next = S_RST;
                  OP_NONE:  state_next = S_IDLE;
               endcase
            end
         end
         S_RD:     if (cnt_zero) state_next = S_DONE;
         S_WR:     if (cnt_zero) state_next = S_WR_GAP;
         S_WR_GAP: if (cnt_zero) state_next = S_DONE;
         S_RST:    if (cnt_zero) state_next = S_RST_WT;
         // hold off until busy released or recovery expires
         S_RST_WT: if (cnt_zero || rdy_sync) state_next = S_RST_RH;
         S_RST_RH: if (cnt_zero) state_next = S_DONE;
         S_DONE:   state_next = S_IDLE;
         default:  state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         // flash reset pin follows ours, so its read delay applies too
         state_reg <= S_RST_RH;
      end else begin
         state_reg <= state_next;
      end
   end

   // every phase length is a parameter so simulation may shorten it
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_reg <= CW'(RH_CYC);
      end else if (state_reg == S_IDLE && REQ_VALID) begin
         unique case (REQ_OP)
            OP_READ:  cnt_reg <= CW'(SEL_CYC);
            OP_WRITE: cnt_reg <= CW'(WP_CYC);
            OP_RESET: cnt_reg <= CW'(RP_CYC);
            OP_NONE:  cnt_reg <= '0;
         endcase
      end else if (state_reg != state_next) begin
         unique case (state_next)
            S_WR_GAP: cnt_reg <= CW'(WP_CYC);
            S_RST_WT: cnt_reg <= CW'(READY_CYC);
            S_RST_RH: cnt_reg <= CW'(RH_CYC);
            default:  cnt_reg <= '0;
         endcase
      end else if (!cnt_zero) begin
         cnt_reg <= cnt_reg - CW'(1);
      end
   end

   // pin drive: select dropped between cycles so each is a fresh access
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         FL_CE_N       <= 1'b1;
         FL_OE_N       <= 1'b1;
         FL_WE_N       <= 1'b1;
         DATA_LINES_OE <= 1'b0;
      end else begin
         FL_CE_N       <= ~(state_next == S_RD || state_next == S_WR);
         FL_OE_N       <= ~(state_next == S_RD);
         FL_WE_N       <= ~(state_next == S_WR);
         DATA_LINES_OE <= (state_next == S_WR);
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         FL_RESET_N <= 1'b0;
      end else begin
         FL_RESET_N <= ~(state_next == S_RST);
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         FL_ADDR          <= '0;
         DATA_LINES_O     <= '0;
         WORD_BYTE_SELECT <= 1'b1;
      end else if (state_reg == S_IDLE && REQ_VALID) begin
         FL_ADDR          <= REQ_ADDR;
         DATA_LINES_O     <= REQ_WDATA;
         WORD_BYTE_SELECT <= ~REQ_BYTE_MODE;
      end
   end

   // pin is always driven, never floated; high voltage only on request
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PROTECT_ACCEL_PIN  <= 1'b1;
         ACCEL_HIGH_VOLTAGE <= 1'b0;
      end else if (state_reg == S_IDLE) begin
         PROTECT_ACCEL_PIN  <= 1'b1;
         ACCEL_HIGH_VOLTAGE <= REQ_VALID && REQ_ACCEL
                               && REQ_OP == OP_WRITE;
      end
   end
   assign ACCEL_ACTIVE = ACCEL_HIGH_VOLTAGE;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RSP_RDATA <= '0;
         RSP_BANK  <= '0;
      end else if (state_reg == S_RD && cnt_zero) begin
         RSP_RDATA <= DATA_LINES_I;
         RSP_BANK  <= FL_ADDR[`BANK_MSB:`BANK_LSB];
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         RSP_VALID <= 1'b0;
      end else begin
         RSP_VALID <= (state_next == S_DONE);
      end
   end

   AST_READ_PINS: assert property (@(posedge CLK) disable iff (!RESET_N)
      !FL_OE_N |-> (!FL_CE_N && FL_WE_N && !DATA_LINES_OE))
      else $error("read pins wrong");
   AST_WRITE_PINS: assert property (@(posedge CLK) disable iff (!RESET_N)
      !FL_WE_N |-> (!FL_CE_N && FL_OE_N && DATA_LINES_OE))
      else $error("write pins wrong");
   AST_RESET_WIDTH: assert property (@(posedge CLK) disable iff (!RESET_N)
      $fell(FL_RESET_N) |-> !FL_RESET_N [*2])
      else $error("reset pulse short");
   AST_RESET_IDLE: assert property (@(posedge CLK) disable iff (!RESET_N)
      !FL_RESET_N |-> (FL_CE_N && FL_WE_N && FL_OE_N))
      else $error("access during reset");
   AST_READ_WAIT: assert property (@(posedge CLK) disable iff (!RESET_N)
      $fell(FL_OE_N) |-> !FL_OE_N [*2])
      else $error("read too short");
   AST_RH_WAIT: assert property (@(posedge CLK) disable iff (!RESET_N)
      $rose(FL_RESET_N) |-> FL_OE_N [*2])
      else $error("read too soon after reset");
   AST_ACCEL_WR: assert property (@(posedge CLK) disable iff (!RESET_N)
      (ACCEL_HIGH_VOLTAGE && state_reg != S_IDLE) |-> FL_OE_N)
      else $error("high voltage outside program");
   AST_RSP_AFTER_RD: assert property (@(posedge CLK) disable iff (!RESET_N)
      (state_reg == S_RD && cnt_zero) |=> RSP_VALID)
      else $error("missing response");
   COV_READ:  cover property (@(posedge CLK) $rose(RSP_VALID) && FL_CE_N);
   COV_WRITE: cover property (@(posedge CLK) $fell(FL_WE_N));
   COV_RESET: cover property (@(posedge CLK) $rose(FL_RESET_N));
   COV_ACCEL: cover property (@(posedge CLK) ACCEL_HIGH_VOLTAGE);
endmodule

// >>> flash_host_defines.svh
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH
`define CLK_PERIOD_NS        25
`define ADDR_ACCESS_NS       70
`define CE_ACCESS_NS         70
`define WRITE_PULSE_NS       35
`define RESET_PULSE_NS       500
`define RESET_READY_NS       20000
`define RESET_TO_READ_NS     50
`define SLEEP_EXTRA_NS       30
`define CYC_UP(ns)   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CYC      `CYC_UP(`ADDR_ACCESS_NS)
`define CE_CYC       `CYC_UP(`CE_ACCESS_NS)
`define WP_CYC       `CYC_UP(`WRITE_PULSE_NS)
`define RP_CYC       `CYC_UP(`RESET_PULSE_NS)
`define READY_CYC    `CYC_UP(`RESET_READY_NS)
`define RH_CYC       `CYC_UP(`RESET_TO_READ_NS)
`define SLEEP_CYC    `CYC_UP(`ADDR_ACCESS_NS + `SLEEP_EXTRA_NS)
`define BANK_MSB     21
`define BANK_LSB     20
`endif

// >>> flash_host_pkg.sv
package flash_host_pkg;
   typedef enum logic [3:0] {
      S_IDLE    = 4'b0000,
      S_RD      = 4'b0001,
      S_WR      = 4'b0010,
      S_WR_GAP  = 4'b0011,
      S_RST     = 4'b0100,
      S_RST_WT  = 4'b0101,
      S_RST_RH  = 4'b0110,
      S_DONE    = 4'b0111
   } host_state_t;
   typedef enum logic [1:0] {
      OP_READ  = 2'b00,
      OP_WRITE = 2'b01,
      OP_RESET = 2'b10,
      OP_NONE  = 2'b11
   } host_op_t;
endpackage

// >>> sync3.sv
`timescale 1ns/1ps
module sync3 (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic d,
   output logic      q
);
   logic [2:0] sh_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sh_reg <= 3'h7;
      end else begin
         sh_reg <= {sh_reg[1:0], d};
      end
   end
   // change taken only when stages two and three agree
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= 1'b1;
      end else if (sh_reg[1] == sh_reg[2]) begin
         q <= sh_reg[2];
      end
   end
endmodule

// >>> flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model (
   input  wire logic        clk,
   input  wire logic [21:0] addr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        rst_n,
   input  wire logic        word_sel,
   input  wire logic [15:0] din,
   input  wire logic        din_oe,
   output logic             ready_busy_n,
   output logic [15:0]      dout
);
   logic [15:0] mem [256];
   logic [15:0] last_reg;
   logic [2:0]  busy_reg;
   logic [7:0]  idx;
   logic        drive;
   logic [1:0]  acc_reg;
   logic        valid;
   assign idx = {addr[21:20], addr[5:0]};
   assign drive = !ce_n && !oe_n && we_n && rst_n;
   // data valid only two edges into the access, so early sampling fails
   assign valid = drive && acc_reg[1];
   // a released bus shows the inverse of its last value, never a stale copy
   assign dout = valid ? {word_sel ? mem[idx][15:8] : ~last_reg[15:8],
                          mem[idx][7:0]} : ~last_reg;
   assign ready_busy_n = (busy_reg == 3'h0) && rst_n;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'hA5C3 ^ (i * 16'h0101);
      end
      last_reg = 16'h0000;
      busy_reg = 3'h0;
      acc_reg = 2'h0;
   end
   always @(posedge clk) begin
      if (valid) last_reg <= dout;
      if (!drive) acc_reg <= 2'h0;
      else if (!acc_reg[1]) acc_reg <= acc_reg + 2'h1;
      if (!rst_n) begin
         busy_reg <= 3'h3;
      end else if (!ce_n && !we_n && din_oe) begin
         mem[idx] <= word_sel ? din : {mem[idx][15:8], din[7:0]};
         busy_reg <= 3'h6;
      end else if (busy_reg != 3'h0) begin
         busy_reg <= busy_reg - 3'h1;
      end
   end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   import flash_host_pkg::*;
   logic clk = 0, reset_n = 0, req_valid = 0, req_byte_mode = 0;
   logic req_accel = 0, req_ready, rsp_valid, accel_active, dev_busy;
   host_op_t req_op = OP_NONE;
   logic [21:0] req_addr = 0, fl_addr;
   logic [15:0] req_wdata = 0, rsp_rdata, dl_i, dl_o;
   logic [1:0] rsp_bank;
   logic fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, wbs, pap, ahv, rbn, dl_oe;
   logic [15:0] exp_mem [256];
   int fails = 0, checked = 0, cycles = 0, seed;
   always #12.5 clk = ~clk;
   flash_host_ctrl #(.RP_CYC(4), .READY_CYC(10)) dut (
      .CLK(clk), .RESET_N(reset_n), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_ADDR(req_addr),
      .REQ_WDATA(req_wdata), .REQ_BYTE_MODE(req_byte_mode),
      .REQ_ACCEL(req_accel), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
      .RSP_BANK(rsp_bank), .ACCEL_ACTIVE(accel_active), .DEV_BUSY(dev_busy),
      .FL_ADDR(fl_addr), .FL_CE_N(fl_ce_n), .FL_OE_N(fl_oe_n),
      .FL_WE_N(fl_we_n), .FL_RESET_N(fl_reset_n), .WORD_BYTE_SELECT(wbs),
      .PROTECT_ACCEL_PIN(pap), .ACCEL_HIGH_VOLTAGE(ahv),
      .READY_BUSY_N(rbn), .DATA_LINES_I(dl_i), .DATA_LINES_O(dl_o),
      .DATA_LINES_OE(dl_oe));
   flash_dev_model dev (
      .clk(clk), .addr(fl_addr), .ce_n(fl_ce_n), .oe_n(fl_oe_n),
      .we_n(fl_we_n), .rst_n(fl_reset_n), .word_sel(wbs), .din(dl_o),
      .din_oe(dl_oe), .ready_busy_n(rbn), .dout(dl_i));
   function automatic logic [7:0] idx(input logic [21:0] a);
      return {a[21:20], a[5:0]};
   endfunction
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic do_op(input host_op_t op, input logic [21:0] a,
                        input logic [15:0] d, input logic bm, input logic acc);
      logic rdy, ce_seen, rst_seen, busy_seen;
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_wdata <= d;
      req_byte_mode <= bm;
      req_accel <= acc;
      rdy = 1'b0;
      while (!rdy) begin
         @(negedge clk);
         rdy = (req_ready === 1'b1);
         @(posedge clk);
      end
      req_valid <= 1'b0;
      n = 0;
      ce_seen = 0;
      rst_seen = 0;
      busy_seen = 0;
      do begin
         @(negedge clk);
         n++;
         chk("protect pin", pap, 1'b1);
         if (fl_reset_n === 1'b0) rst_seen = 1;
         if (dev_busy === 1'b1) busy_seen = 1;
         if (fl_ce_n === 1'b0) begin
            ce_seen = 1;
            chk("address", fl_addr, a);
            chk("width select", wbs, !bm);
            if (op == OP_WRITE) begin
               chk("write pins", {fl_oe_n, dl_oe, dl_o}, {2'b11, d});
               chk("accel", {ahv, accel_active}, {acc, acc});
            end else chk("read pins", {fl_we_n, ahv}, 2'b10);
         end
      end while (rsp_valid !== 1'b1 && n < 200);
      chk("answer", n < 200, 1);
      chk("pins used", {ce_seen, rst_seen},
          (op == OP_RESET) ? 2'b01 : 2'b10);
      if (op == OP_RESET)
         chk("busy", {busy_seen, dev_busy}, 2'b10);
      if (op == OP_READ) begin
         if (bm) chk("byte data", rsp_rdata[7:0], exp_mem[idx(a)][7:0]);
         else chk("word data", rsp_rdata, exp_mem[idx(a)]);
         chk("bank", rsp_bank, a[21:20]);
      end
      if (op == OP_WRITE)
         exp_mem[idx(a)] = bm ? {exp_mem[idx(a)][15:8], d[7:0]} : d;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      logic [21:0] a;
      logic [15:0] d;
      int k;
      seed = 80;
      for (int i = 0; i < 256; i++) exp_mem[i] = 16'hA5C3 ^ (i * 16'h0101);
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      do_op(OP_READ, 22'h000005, 16'h0000, 0, 0);
      for (int b = 0; b < 4; b++) begin
         a = {b[1:0], 20'h00011};
         d = $random(seed);
         do_op(OP_WRITE, a, d, 0, b[0]);
         // read another bank while this one still programs
         do_op(OP_READ, {a[21:20] + 2'h1, 20'h00011}, 16'h0000, 0, 0);
         do_op(OP_READ, a, 16'h0000, 0, 0);
      end
      do_op(OP_WRITE, 22'h100022, 16'h1234, 1, 0);
      do_op(OP_RESET, 22'h000000, 16'h0000, 0, 0);
      do_op(OP_WRITE, 22'h100022, 16'h1234, 1, 0);
      do_op(OP_READ, 22'h100022, 16'h0000, 0, 0);
      for (int i = 0; i < 50; i++) begin
         k = $random(seed) & 7;
         a = $random(seed);
         d = $random(seed);
         if (k == 7) do_op(OP_RESET, a, d, 0, 0);
         else if (k < 3) do_op(OP_WRITE, a, d, k[0], k[1]);
         else do_op(OP_READ, a, d, k[0], 0);
      end
      report_and_stop();
   end
endmodule
